// File: hdl/irq_arb_cfg.svh
// Constants for the interrupt arbiter
`ifndef IRQ_ARB_CFG_SVH
`define IRQ_ARB_CFG_SVH

`define CLK_NS          25
`define BUSMON_NS       1600
`define BUSMON_CYC      (`BUSMON_NS / `CLK_NS)
`define PIN_W           10
`define MASK_RST        3'h7
`define SIM_ARB_ID_RST  4'hF
`define FC_CPU_SPACE    3'h7
`define IACK_ADDR_HI    20'hFFFFF
`define VEC_SPURIOUS    8'h18
`define VEC_AUTO_BASE   8'h18
`define PIN_IRQ_LSB     0
`define PIN_AUTOVECTOR_REQUEST        7
`define PIN_SACK_LSB    8

`endif

// File: hdl/irq_arb_pkg.sv
// Types shared by the interrupt arbiter
package irq_arb_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_STACK,
        ST_ACK,
        ST_ARB,
        ST_EXT,
        ST_VEC,
        ST_FETCH
    } iack_state_t;

    typedef struct packed {
        logic [2:0]  fc;
        logic [23:0] addr;
    } iack_bus_t;

    typedef struct packed {
        logic [2:0] level;
        logic [3:0] id;
        logic [7:0] vector;
    } requester_t;

endpackage : irq_arb_pkg

// File: hdl/pin_filter.sv
// Three-stage pin synchroniser that accepts a level once two samples agree
`timescale 1ns/100ps
`include "irq_arb_cfg.svh"

module pin_filter (
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_b_i,
    // Raw pins and filtered levels
    input  wire logic [`PIN_W-1:0] pin_i,
    output logic      [`PIN_W-1:0] level_o
);

    typedef struct packed {
        logic [`PIN_W-1:0] s1;
        logic [`PIN_W-1:0] s2;
        logic [`PIN_W-1:0] s3;
        logic [`PIN_W-1:0] lvl;
    } filt_t;

    filt_t s;
    filt_t next_s;

    logic [`PIN_W-1:0] next_lvl;

    genvar g;
    generate
        for (g = 0; g < `PIN_W; g++) begin : g_bit
            // (R6) two agreeing samples
            assign next_lvl[g] = (s.s2[g] == s.s3[g]) ? s.s2[g] : s.lvl[g];
        end
    endgenerate

    always_comb begin
        next_s     = s;
        next_s.s1  = pin_i;
        next_s.s2  = s.s1;
        next_s.s3  = s.s2;
        next_s.lvl = next_lvl;
    end

    // Pins idle high, so the chain starts deasserted
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= '{default: '1};
        end else begin
            s <= next_s;
        end
    end

    assign level_o = s.lvl;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    chk_filter_two_samples: // (R6)
        assert property ((s.s2 != s.lvl) && (s.s2 == s.s3) |=> s.lvl == $past(s.s2))
        else $error("filter missed agreeing samples");

endmodule : pin_filter

// File: hdl/irq_priority_arbiter.sv
// Interrupt recognition, acknowledge cycle and arbitration-ID contention
// What this block does and what it expects of sources and software
// (R1) Seven active-low request levels, seven highest
// (R2) Ignore requests at or below the mask
// (R3) Level seven always recognized
// (R4) Sources hold request until acknowledged
// (R5) Level seven edge-detected, re-armed by mask write
// (R6) Request valid after two stable samples
// (R7) Pending serviced at boundary, level not latched
// (R8) Higher of simultaneous requests wins
// (R9) Acknowledge drives CPU space, all-ones, level
// (R10) Acknowledged level copied into mask
// (R11) Stack state, set supervisor, clear trace
// (R12) Requesters contend only at matching level
// (R13) Serial four-bit ID contention, highest wins
// (R14) No contender: bus error, spurious vector
// (R15) Software assigns unique nonzero arbitration IDs
// (R16) Unit ID resets to all ones
// (R17) Always arbitrate; external only if unit wins
// (R18) Winner terminates with vector or autovector
// (R19) Autovector number follows acknowledged level
// (R20) Bus monitor timeout gives spurious exception
// (R21) Chip-select acknowledge only on external cycle
// (R22) Timer field zero disables; timer beats pins
// (R23) Vector address is base plus scaled number
`timescale 1ns/100ps
`include "irq_arb_cfg.svh"

module irq_priority_arbiter (
    // Clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    rst_b_i,
    // External pins
    input  wire logic [7:1]              irq_req_b_i,
    input  wire logic [1:0]              size_acknowledge_b_i,
    input  wire logic                    autovector_request_b_i,
    input  wire logic [7:0]              ext_data_i,
    input  wire logic                    bus_monitor_en_i,
    // Internal module requester
    input  wire irq_arb_pkg::requester_t int_req_i,
    // Periodic timer
    input  wire logic [2:0]              periodic_level_field_i,
    input  wire logic                    periodic_req_i,
    input  wire logic [7:0]              periodic_vector_i,
    // Processor side
    input  wire logic                    boundary_i,
    input  wire logic                    mask_write_i,
    input  wire logic [2:0]              mask_wdata_i,
    input  wire logic                    sr_write_i,
    input  wire logic [2:0]              sr_wdata_i,
    input  wire logic                    arb_id_write_i,
    input  wire logic [3:0]              arb_id_wdata_i,
    input  wire logic [31:0]             vector_table_base_i,
    input  wire logic [31:0]             fetch_data_i,
    input  wire logic                    fetch_done_i,
    // Acknowledge cycle
    output irq_arb_pkg::iack_bus_t       iack_bus_o,
    output logic                         ext_cycle_o,
    output logic                         chip_select_ack_en_o,
    output logic                         bus_error_signal_o,
    output logic                         int_ack_o,
    // Processor state
    output logic [2:0]                   priority_mask_o,
    output logic                         supervisor_o,
    output logic                         trace_bit_high_o,
    output logic                         trace_bit_low_o,
    output logic                         save_state_o,
    output logic [3:0]                   arbitration_id_field_o,
    // Vector fetch
    output logic [7:0]                   vector_number_o,
    output logic [31:0]                  vector_address_o,
    output logic                         vector_fetch_o,
    output logic [31:0]                  program_counter_o,
    output logic                         pc_load_o
);

    typedef struct packed {
        irq_arb_pkg::iack_state_t st;
        logic [2:0]               mask;
        logic                     nmi_pend;
        logic                     irq7_prev;
        logic [3:0]               arb_id;
        logic [2:0]               lvl;
        logic [1:0]               bit_idx;
        logic [1:0]               alive;
        logic [3:0]               acc;
        logic [6:0]               timer;
        irq_arb_pkg::iack_bus_t   bus;
        logic                     ext_cycle;
        logic                     cs_en;
        logic                     bus_error_signal;
        logic                     int_ack;
        logic                     sup;
        logic                     t1;
        logic                     t0;
        logic                     save_pulse;
        logic [7:0]               vec;
        logic [31:0]              vaddr;
        logic                     fetch;
        logic [31:0]              pc;
        logic                     pc_load;
    } ctl_t;

    ctl_t s;
    ctl_t next_s;

    logic [`PIN_W-1:0] pins;
    logic [6:0]        irq_act;
    logic [6:0]        sim_act;
    logic [6:0]        all_act;
    logic [6:0]        eff_act;
    logic [2:0]        cur;
    logic              recog;
    logic              lvl7;
    logic              sack;
    logic              autovector_request;
    logic              wired;
    logic [1:0]        alive_n;
    logic [3:0]        acc_n;
    logic              pit_at_lvl;

    // One-hot of a level; level zero means no request
    function automatic logic [6:0] lvl_bit(input logic [2:0] l);
        lvl_bit = 7'h00;
        if (l != 3'h0) begin
            lvl_bit[l - 3'h1] = 1'b1;
        end
    endfunction : lvl_bit

    // (R8) highest active level
    function automatic logic [2:0] top_level(input logic [6:0] v);
        top_level = 3'h0;
        for (int i = 0; i < 7; i++) begin
            if (v[i]) begin
                top_level = 3'(i + 1);
            end
        end
    endfunction : top_level

    pin_filter u_pins (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .pin_i   ({size_acknowledge_b_i, autovector_request_b_i, irq_req_b_i}),
        .level_o (pins)
    );

    always_comb begin
        // (R1) active-low pins
        irq_act = ~pins[`PIN_IRQ_LSB +: 7];
        autovector_request    = ~pins[`PIN_AUTOVECTOR_REQUEST];
        sack    = ~(&pins[`PIN_SACK_LSB +: 2]);
        // (R22) zero field disables timer
        sim_act = irq_act | ((periodic_level_field_i != 3'h0 && periodic_req_i)
                             ? lvl_bit(periodic_level_field_i) : 7'h00);
        all_act = sim_act | lvl_bit(int_req_i.level);
        lvl7    = all_act[6];
        // (R5) level seven counts only when armed
        eff_act = all_act & {s.nmi_pend, 6'h3F};
        cur     = top_level(eff_act);
        // (R2) (R3) mask compare, seven never masked
        recog   = (cur == 3'h7) || (cur > s.mask);
        pit_at_lvl = periodic_req_i && (periodic_level_field_i == s.lvl) && (s.lvl != 3'h0);
        // (R13) wired-OR of contenders' current ID bit
        wired   = (s.alive[0] & s.arb_id[s.bit_idx]) | (s.alive[1] & int_req_i.id[s.bit_idx]);
        alive_n = s.alive;
        acc_n   = s.acc;
        acc_n[s.bit_idx] = wired;
        if (wired) begin
            alive_n[0] = s.alive[0] & s.arb_id[s.bit_idx];
            alive_n[1] = s.alive[1] & int_req_i.id[s.bit_idx];
        end
    end

    always_comb begin
        next_s            = s;
        next_s.save_pulse = 1'b0;
        next_s.fetch      = 1'b0;
        next_s.pc_load    = 1'b0;
        next_s.bus_error_signal       = 1'b0;
        next_s.int_ack    = 1'b0;
        next_s.irq7_prev  = lvl7;
        if (mask_write_i) begin
            next_s.mask = mask_wdata_i;
        end
        if (sr_write_i) begin
            {next_s.sup, next_s.t1, next_s.t0} = sr_wdata_i;
        end
        if (arb_id_write_i) begin
            next_s.arb_id = arb_id_wdata_i;
        end
        case (s.st)
            irq_arb_pkg::ST_IDLE: begin
                // (R7) service only at a boundary
                if (boundary_i && cur != 3'h0 && recog) begin
                    next_s.st = irq_arb_pkg::ST_STACK;
                end
            end
            irq_arb_pkg::ST_STACK: begin
                // (R11) stack, supervisor, trace off
                next_s.save_pulse = 1'b1;
                next_s.sup        = 1'b1;
                next_s.t1         = 1'b0;
                next_s.t0         = 1'b0;
                // (R7) take the newest level, not a latched one
                next_s.lvl        = cur;
                next_s.st = (cur != 3'h0 && recog) ? irq_arb_pkg::ST_ACK : irq_arb_pkg::ST_IDLE;
            end
            irq_arb_pkg::ST_ACK: begin
                // (R9) CPU space acknowledge address
                next_s.bus.fc   = `FC_CPU_SPACE;
                next_s.bus.addr = {`IACK_ADDR_HI, s.lvl, 1'b1};
                // (R10) mask follows the acknowledged level
                next_s.mask     = s.lvl;
                // (R12) (R4) only sources holding this level contend
                next_s.alive[0] = sim_act[s.lvl - 3'h1] && s.arb_id != 4'h0;
                next_s.alive[1] = int_req_i.level == s.lvl && int_req_i.id != 4'h0;
                next_s.bit_idx  = 2'h3;
                next_s.acc      = 4'h0;
                next_s.st       = irq_arb_pkg::ST_ARB;
            end
            irq_arb_pkg::ST_ARB: begin
                // (R13) one ID bit per cycle, MSB first
                next_s.alive   = alive_n;
                next_s.acc     = acc_n;
                next_s.bit_idx = s.bit_idx - 2'h1;
                if (s.bit_idx == 2'h0) begin
                    if (acc_n == 4'h0) begin
                        // (R14) (R17) nobody contended
                        next_s.bus_error_signal = 1'b1;
                        next_s.vec  = `VEC_SPURIOUS;
                        next_s.st   = irq_arb_pkg::ST_VEC;
                    end else if (alive_n[0] && pit_at_lvl) begin
                        // (R22) timer beats pins
                        next_s.vec = periodic_vector_i;
                        next_s.st  = irq_arb_pkg::ST_VEC;
                    end else if (alive_n[0]) begin
                        // (R17) (R21) unit won: go external
                        next_s.ext_cycle = 1'b1;
                        next_s.cs_en     = 1'b1;
                        next_s.timer     = 7'h00;
                        next_s.st        = irq_arb_pkg::ST_EXT;
                    end else begin
                        // (R18) internal winner's vector
                        next_s.int_ack = 1'b1;
                        next_s.vec     = int_req_i.vector;
                        next_s.st      = irq_arb_pkg::ST_VEC;
                    end
                end
            end
            irq_arb_pkg::ST_EXT: begin
                next_s.timer = s.timer + 7'h01;
                if (sack || autovector_request || (bus_monitor_en_i && s.timer == 7'(`BUSMON_CYC - 1))) begin
                    next_s.ext_cycle = 1'b0;
                    next_s.cs_en     = 1'b0;
                    next_s.st        = irq_arb_pkg::ST_VEC;
                end
                if (sack) begin
                    // (R18) device vector with size acknowledge
                    next_s.vec = ext_data_i;
                end else if (autovector_request) begin
                    // (R19) autovector from level
                    next_s.vec = `VEC_AUTO_BASE + {5'h00, s.lvl};
                end else if (bus_monitor_en_i && s.timer == 7'(`BUSMON_CYC - 1)) begin
                    // (R20) bus monitor timeout
                    next_s.bus_error_signal = 1'b1;
                    next_s.vec  = `VEC_SPURIOUS;
                end
            end
            irq_arb_pkg::ST_VEC: begin
                next_s.bus   = '0;
                // (R23) base plus long-word displacement
                next_s.vaddr = vector_table_base_i + {22'h0, s.vec, 2'b00};
                next_s.fetch = 1'b1;
                next_s.st    = irq_arb_pkg::ST_FETCH;
            end
            irq_arb_pkg::ST_FETCH: begin
                if (fetch_done_i) begin
                    // (R23) fetched content to PC
                    next_s.pc      = fetch_data_i;
                    next_s.pc_load = 1'b1;
                    next_s.st      = irq_arb_pkg::ST_IDLE;
                end
            end
            default: begin
                next_s.st = irq_arb_pkg::ST_IDLE;
            end
        endcase
        // (R5) new edge or mask write re-arms; set wins over clear
        if ((lvl7 && !s.irq7_prev) || (mask_write_i && lvl7)) begin
            next_s.nmi_pend = 1'b1;
        end else if (s.st == irq_arb_pkg::ST_ACK && s.lvl == 3'h7) begin
            next_s.nmi_pend = 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s        <= '0;
            s.st     <= irq_arb_pkg::ST_IDLE;
            s.mask   <= `MASK_RST;
            s.sup    <= 1'b1;
            // (R16) unit ID out of reset
            s.arb_id <= `SIM_ARB_ID_RST;
        end else begin
            s <= next_s;
        end
    end

    assign iack_bus_o             = s.bus;
    assign ext_cycle_o            = s.ext_cycle;
    assign chip_select_ack_en_o   = s.cs_en;
    assign bus_error_signal_o     = s.bus_error_signal;
    assign int_ack_o              = s.int_ack;
    assign priority_mask_o        = s.mask;
    assign supervisor_o           = s.sup;
    assign trace_bit_high_o       = s.t1;
    assign trace_bit_low_o        = s.t0;
    assign save_state_o           = s.save_pulse;
    assign arbitration_id_field_o = s.arb_id;
    assign vector_number_o        = s.vec;
    assign vector_address_o       = s.vaddr;
    assign vector_fetch_o         = s.fetch;
    assign program_counter_o      = s.pc;
    assign pc_load_o              = s.pc_load;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    chk_mask_ignore: // (R2)
        assert property ((cur != 3'h0) && (cur != 3'h7) && (cur <= s.mask) |-> !recog)
        else $error("masked request recognized");
    chk_nmi_edge: // (R5)
        assert property ((lvl7 && !s.irq7_prev) |=> s.nmi_pend)
        else $error("level seven edge not armed");
    chk_stack_state: // (R11)
        assert property ((s.st == irq_arb_pkg::ST_STACK) |=> s.save_pulse && s.sup && !s.t1 && !s.t0)
        else $error("state not stacked");
    chk_iack_address: // (R9)
        assert property ((s.st == irq_arb_pkg::ST_ARB) |-> s.bus.fc == `FC_CPU_SPACE
                         && s.bus.addr == {`IACK_ADDR_HI, s.lvl, 1'b1})
        else $error("acknowledge address wrong");
    chk_mask_takes_lvl: // (R10)
        assert property ((s.st == irq_arb_pkg::ST_ACK) |=> s.mask == $past(s.lvl))
        else $error("mask missed acknowledged level");
    chk_arb_four_bits: // (R13)
        assert property ((s.st == irq_arb_pkg::ST_ACK) |=> (s.st == irq_arb_pkg::ST_ARB) [*4]
                         ##1 (s.st != irq_arb_pkg::ST_ARB))
        else $error("contention not four cycles");
    chk_spurious_bus_error_signal: // (R14)
        assert property ((s.st == irq_arb_pkg::ST_ARB) && (s.bit_idx == 2'h0) && (acc_n == 4'h0)
                         |=> s.bus_error_signal && s.vec == `VEC_SPURIOUS ##1 s.fetch)
        else $error("no contender without bus error");
    chk_ext_unit_won: // (R21)
        assert property (s.ext_cycle |-> s.cs_en && s.alive[0] && s.st == irq_arb_pkg::ST_EXT)
        else $error("external cycle without unit winning");
    chk_autovector: // (R19)
        assert property ((s.st == irq_arb_pkg::ST_EXT) && autovector_request && !sack
                         |=> s.vec == `VEC_AUTO_BASE + {5'h00, $past(s.lvl)})
        else $error("autovector number wrong");
    chk_busmon_bound: // (R20)
        assert property ((s.st == irq_arb_pkg::ST_EXT) |-> s.timer < 7'(`BUSMON_CYC))
        else $error("bus monitor overran");

endmodule : irq_priority_arbiter

// File: verification/ext_irq_source.sv
// Behavioural external interrupting device
`timescale 1ns/100ps

module ext_irq_source (
    // Clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   rst_b_i,
    // Bench control
    input  wire logic                   go_i,
    input  wire logic [2:0]             level_i,
    input  wire logic [1:0]             mode_i,
    input  wire logic [7:0]             vector_i,
    input  wire logic [2:0]             delay_i,
    // Device side
    input  wire irq_arb_pkg::iack_bus_t iack_bus_i,
    input  wire logic                   ext_cycle_i,
    output logic      [7:1]             irq_req_b_o,
    output logic      [1:0]             size_acknowledge_b_o,
    output logic                        autovector_request_b_o,
    output logic      [7:0]             ext_data_o
);
    logic       pend;
    logic       resp;
    logic       mine;
    logic [2:0] cnt;

    assign mine = iack_bus_i.fc == 3'h7 && iack_bus_i.addr[3:1] == level_i;

    // hold request until its external acknowledge, answer after a delay
    always @(negedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend <= 1'b0;
            resp <= 1'b0;
            cnt  <= 3'h0;
        end else begin
            pend <= go_i || (pend && !(mine && ext_cycle_i));
            cnt  <= (ext_cycle_i && mine && !resp) ? cnt + 3'h1 : 3'h0;
            resp <= ext_cycle_i && mine && (resp || cnt == delay_i);
        end
    end

    assign irq_req_b_o            = pend ? ~(7'h01 << (level_i - 3'h1)) : 7'h7F;
    assign size_acknowledge_b_o   = (resp && mode_i == 2'h0) ? 2'h0 : 2'h3;
    assign autovector_request_b_o = !(resp && mode_i == 2'h1);
    // Released data shows the inverse, so no stale vector passes
    assign ext_data_o             = (resp && mode_i == 2'h0) ? vector_i : ~vector_i;
endmodule : ext_irq_source

// File: verification/tb_irq_priority_arbiter.sv
// Self-checking bench for the interrupt arbiter
`timescale 1ns/100ps

module tb_irq_priority_arbiter;
    logic                    clock_i, rst_b_i, autovector_request_b_i, bus_monitor_en_i, periodic_req_i, boundary_i;
    logic                    mask_write_i, sr_write_i, arb_id_write_i, fetch_done_i, ext_cycle_o, chip_select_ack_en_o;
    logic                    bus_error_signal_o, int_ack_o, supervisor_o, trace_bit_high_o, trace_bit_low_o;
    logic                    save_state_o, vector_fetch_o, pc_load_o, p_go;
    logic [1:0]              size_acknowledge_b_i, p_mode;
    logic [2:0]              periodic_level_field_i, mask_wdata_i, sr_wdata_i, priority_mask_o, p_lvl, p_dly, lvl;
    logic [3:0]              arb_id_wdata_i, arbitration_id_field_o;
    logic [7:0]              ext_data_i, periodic_vector_i, vector_number_o, p_vec, v, v2;
    logic [7:1]              irq_req_b_i;
    logic [31:0]             vector_table_base_i, fetch_data_i, vector_address_o, program_counter_o;
    logic [15:0]             seed;
    irq_arb_pkg::requester_t int_req_i;
    irq_arb_pkg::iack_bus_t  iack_bus_o;
    int                      errors, check_count, bus_error_signal_n, int_n, cs_n, save_n, pc_n;
    int                      i0, c0, s0;

    irq_priority_arbiter irq_priority_arbiter_i (
        .clock_i, .rst_b_i, .irq_req_b_i, .size_acknowledge_b_i, .autovector_request_b_i, .ext_data_i,
        .bus_monitor_en_i, .int_req_i, .periodic_level_field_i, .periodic_req_i, .periodic_vector_i, .boundary_i,
        .mask_write_i, .mask_wdata_i, .sr_write_i, .sr_wdata_i, .arb_id_write_i, .arb_id_wdata_i,
        .vector_table_base_i, .fetch_data_i, .fetch_done_i, .iack_bus_o, .ext_cycle_o, .chip_select_ack_en_o,
        .bus_error_signal_o, .int_ack_o, .priority_mask_o, .supervisor_o, .trace_bit_high_o, .trace_bit_low_o,
        .save_state_o, .arbitration_id_field_o, .vector_number_o, .vector_address_o, .vector_fetch_o,
        .program_counter_o, .pc_load_o
    );

    ext_irq_source ext_irq_source_i (
        .clock_i, .rst_b_i, .go_i(p_go), .level_i(p_lvl), .mode_i(p_mode), .vector_i(p_vec), .delay_i(p_dly),
        .iack_bus_i(iack_bus_o), .ext_cycle_i(ext_cycle_o), .irq_req_b_o(irq_req_b_i),
        .size_acknowledge_b_o(size_acknowledge_b_i), .autovector_request_b_o(autovector_request_b_i),
        .ext_data_o(ext_data_i)
    );

    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    // Pulses are counted at every rising edge
    always @(posedge clock_i) begin
        if (bus_error_signal_o === 1'b1) bus_error_signal_n++;
        if (int_ack_o === 1'b1) int_n++;
        if (chip_select_ack_en_o === 1'b1) cs_n++;
        if (save_state_o === 1'b1) save_n++;
        if (pc_load_o === 1'b1) pc_n++;
    end

    function automatic logic [7:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction : rnd

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask : tick

    task automatic wait_on(input int which, input int lim);
        int n = 0;
        do begin
            @(posedge clock_i);
            #1;
            n++;
        end while (n < lim && !(which == 0 ? save_state_o === 1'b1
                                : which == 1 ? iack_bus_o.fc === 3'h7 : vector_fetch_o === 1'b1));
        check("handshake", n < lim, 1'b1);
    endtask : wait_on

    task automatic prep(input logic [2:0] mask);
        @(negedge clock_i);
        mask_write_i = 1'b1;
        mask_wdata_i = mask;
        sr_write_i   = 1'b1;
        sr_wdata_i   = 3'h3;
        tick(1);
        mask_write_i = 1'b0;
        sr_write_i   = 1'b0;
        tick(2);
        check("mask write", priority_mask_o, mask);
    endtask : prep

    task automatic arb_write(input logic [3:0] id);
        @(negedge clock_i);
        arb_id_write_i = 1'b1;
        arb_id_wdata_i = id;
        tick(1);
        arb_id_write_i = 1'b0;
        tick(2);
        check("arbitration id", arbitration_id_field_o, id);
    endtask : arb_write

    task automatic raise(input logic [2:0] l, input logic [1:0] mode, input logic [7:0] vec);
        @(negedge clock_i);
        p_lvl  = l;
        p_mode = mode;
        p_vec  = vec;
        p_dly  = 3'(rnd());
        p_go   <= 1'b1;
        tick(1);
        p_go   <= 1'b0;
    endtask : raise

    task automatic serve(input logic [2:0] l, input logic [7:0] vec, input int bus_error_signal);
        int          b0, p0;
        logic [31:0] fd;
        b0 = bus_error_signal_n;
        p0 = pc_n;
        fd = {rnd(), rnd(), rnd(), rnd()};
        @(negedge clock_i);
        boundary_i = 1'b1;
        wait_on(0, 40);
        check("stacked state", {supervisor_o, trace_bit_high_o, trace_bit_low_o}, 3'h4);
        @(negedge clock_i);
        boundary_i = 1'b0;
        wait_on(1, 10);
        check("iack bus", {iack_bus_o.fc, iack_bus_o.addr}, {3'h7, 20'hFFFFF, l, 1'b1});
        check("mask", priority_mask_o, l);
        wait_on(2, 200);
        check("vector", vector_number_o, vec);
        check("vector address", vector_address_o, vector_table_base_i + {22'h0, vec, 2'h0});
        check("bus error", bus_error_signal_n - b0, bus_error_signal);
        @(negedge clock_i);
        fetch_data_i = fd;
        fetch_done_i = 1'b1;
        tick(1);
        fetch_done_i = 1'b0;
        tick(3);
        check("pc", {program_counter_o, 31'(pc_n - p0)}, {fd, 31'h1});
        $display("test level %0d vector %h done", l, vec);
    endtask : serve

    initial begin
        seed = 16'hC61C;
        {rst_b_i, boundary_i, mask_write_i, sr_write_i, arb_id_write_i, fetch_done_i, periodic_req_i, p_go} = 8'h0;
        {mask_wdata_i, sr_wdata_i, periodic_level_field_i, p_lvl, p_dly, p_mode} = 17'h0;
        {arb_id_wdata_i, periodic_vector_i, p_vec, int_req_i, fetch_data_i} = 67'h0;
        bus_monitor_en_i    = 1'b1;
        vector_table_base_i = {rnd(), rnd(), rnd(), rnd()};
        tick(20);
        rst_b_i = 1'b1;
        tick(1);
        check("reset", {priority_mask_o, supervisor_o, trace_bit_high_o, arbitration_id_field_o}, 9'h1EF);
        for (int i = 0; i < 6; i++) begin
            lvl = 3'(i + 1);
            v   = rnd();
            prep(3'h0);
            raise(lvl, 2'(i % 2), v);
            serve(lvl, (i % 2 == 1) ? 8'h18 + 8'(lvl) : v, 0);
        end
        prep(3'h5);
        raise(3'h3, 2'h0, v);
        s0 = save_n;
        boundary_i = 1'b1;
        tick(30);
        boundary_i = 1'b0;
        check("masked", save_n - s0, 0);
        prep(3'h2);
        tick(20);
        check("no boundary", save_n - s0, 0);
        serve(3'h3, v, 0);
        prep(3'h7);
        raise(3'h7, 2'h1, v);
        serve(3'h7, 8'h1F, 0);
        v2 = rnd();
        prep(3'h0);
        raise(3'h5, 2'h0, v);
        tick(5);
        int_req_i = '{level: 3'h4, id: 4'h5, vector: v2};
        serve(3'h5, v, 0);
        arb_write(4'h3);
        raise(3'h4, 2'h0, v);
        prep(3'h0);
        i0 = int_n;
        c0 = cs_n;
        serve(3'h4, v2, 0);
        check("internal win", {int_n - i0, cs_n - c0}, 64'h1_0000_0000);
        int_req_i = '0;
        arb_write(4'hF);
        prep(3'h0);
        serve(3'h4, v, 0);
        periodic_level_field_i = 3'h3;
        periodic_req_i         = 1'b1;
        periodic_vector_i      = v2;
        raise(3'h3, 2'h0, v);
        prep(3'h0);
        serve(3'h3, v2, 0);
        periodic_level_field_i = 3'h0;
        raise(3'h3, 2'h0, v);
        prep(3'h0);
        serve(3'h3, v, 0);
        periodic_req_i = 1'b0;
        arb_write(4'h0);
        raise(3'h1, 2'h0, v);
        prep(3'h0);
        serve(3'h1, 8'h18, 1);
        arb_write(4'hF);
        raise(3'h6, 2'h2, v);
        prep(3'h0);
        serve(3'h6, 8'h18, 1);
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge clock_i);
        errors++;
        end_sim();
    end
endmodule : tb_irq_priority_arbiter
